// ### rtl/pbmux_cfg.svh
// constants for the port b pin function multiplexer
`ifndef PBMUX_CFG_SVH
`define PBMUX_CFG_SVH

// pin index range handled here: pins 1 to 5 of port b
`define PBMUX_PIN_LO 1
`define PBMUX_PIN_HI 5

// individual pin positions
`define PBMUX_PIN_SCLK 1
`define PBMUX_PIN_2    2
`define PBMUX_PIN_3    3
`define PBMUX_PIN_4    4
`define PBMUX_PIN_5    5

// analog enable field positions: channels 8, 9 and 11
`define PBMUX_AN_CH8  0
`define PBMUX_AN_CH9  1
`define PBMUX_AN_CH11 2
`define PBMUX_AN_W    3

// reset values of the registered outputs
`define PBMUX_RST_PIN_OUT  5'h00
`define PBMUX_RST_OE_N     5'h1F
`define PBMUX_RST_ZERO5    5'h00
`define PBMUX_RST_ANALOG   3'h0

// default set of pins used by programming and debug access
`define PBMUX_DBG_MASK_DEF 5'h10

`endif

// ### rtl/pbmux_pkg.sv
// types shared by the port b pin function multiplexer
package pbmux_pkg;

  // power-on sequencing of the analog default
  typedef enum logic [0:0] {
    PBMUX_ST_STRAP = 1'b0,  // first enabled cycle after reset
    PBMUX_ST_RUN   = 1'b1   // normal operation
  } pbmux_state_t;

endpackage

// ### rtl/pbmux_sync_if.sv
// carrier between the multiplexer and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface pbmux_sync_if #(
  parameter int unsigned WIDTH = 5
);
  logic             ce;      // clock enable
  logic [WIDTH-1:0] raw;     // asynchronous pin levels
  logic [WIDTH-1:0] synced;  // levels after two flops

  modport owner (output ce, output raw, input synced);
  modport syncer (input ce, input raw, output synced);
endinterface
`default_nettype wire

// ### rtl/pbmux_sync.sv
// two-flop synchroniser bank for the port b pin inputs
`timescale 1ns/1ps
`default_nettype none
module pbmux_sync
  import pbmux_pkg::*;
#(
  parameter int unsigned WIDTH = 5
)(
  input  wire logic      core_clk_in,
  input  wire logic      reset_in,
  pbmux_sync_if.syncer   sync_bus
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic stage1;       // first flop, read only by stage2
      logic stage2;       // settled level
      logic next_stage1;  // next value of stage1
      logic next_stage2;  // next value of stage2

      // hold while the clock enable is low
      always_comb
      begin
        next_stage1 = sync_bus.ce ? sync_bus.raw[g] : stage1;
        next_stage2 = sync_bus.ce ? stage1 : stage2;
      end

      // register both stages
      always_ff @(posedge core_clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else
        begin
          stage1 <= next_stage1;
          stage2 <= next_stage2;
        end
      end

      assign sync_bus.synced[g] = stage2;
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtl/pbmux_top.sv
// port b pin function multiplexer for pins 1 (serial clock) to 5
//
// Contract
// - output pins drive latch, analog ignored
// - input pins read level, pull-up when control low
// - analog pin loses digital input and pull-up
// - power-on analog default from configuration bit
// - channel 2 on pin 3 when select is 0
// - serial clock output overrides the latch
// - serial port picks the clock input buffer
// - pin 3 compare out or capture in
// - pins 2 and 3 drive usb transceiver
// - pin 2 interrupt, pins 4-5 change interrupts
// - channels 8, 9, 11 on pins 2-4
// - pin 4 drives parallel port select
// - low-voltage programming takes over pin 5
// - programming or debug disables other functions on the DEBUG_PIN_MASK pins
`include "pbmux_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pbmux_top
  import pbmux_pkg::*;
#(
  parameter bit         HAS_PARALLEL_PORT = 1'b1,  // 40/44-pin variant
  parameter logic [5:1] DEBUG_PIN_MASK    = `PBMUX_DBG_MASK_DEF
)(
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  // pins and port registers
  input  wire logic [5:1] pin_level_in,
  input  wire logic [5:1] port_b_output_latch_in,
  input  wire logic [5:1] pin_direction_bit_in,
  input  wire logic       pullup_disable_n_in,
  // configuration bits
  input  wire logic       por_analog_default_in,
  input  wire logic       cc2_pin_select_in,
  input  wire logic       low_voltage_prog_enable_in,
  input  wire logic       in_circuit_programming_in,
  input  wire logic       in_circuit_debug_in,
  // analog channel enables, written by software
  input  wire logic       analog_write_in,
  input  wire logic [2:0] analog_enable_data_in,
  // sync serial port clock
  input  wire logic       ssp_clk_drive_in,
  input  wire logic       ssp_clk_level_in,
  input  wire logic       ssp_i2c_mode_in,
  // capture/compare channel 2
  input  wire logic       cc2_compare_in,
  // usb transceiver
  input  wire logic       usb_xcvr_enable_in,
  input  wire logic       usb_xcvr_minus_data_in,
  input  wire logic       usb_xcvr_plus_data_in,
  // streaming parallel port
  input  wire logic       parallel_port_enable_in,
  input  wire logic       parallel_port_select_in,
  // pin drive
  output logic [5:1]      pin_out,
  output logic [5:1]      pin_oe_n_out,
  output logic [5:1]      pullup_enable_out,
  output logic [5:1]      digital_input_enable_out,
  // reads and peripheral inputs
  output logic [5:1]      port_b_pin_read_out,
  output logic [2:0]      analog_enable_out,
  output logic            ssp_clk_pin_out,
  output logic            i2c_buffer_select_out,
  output logic            cc2_capture_out,
  output logic            cc2_on_port_c_out,
  output logic            ext_irq_2_in_out,
  output logic            change_irq_in_0_out,
  output logic            change_irq_in_1_out,
  output logic            lv_program_entry_out
);

  pbmux_sync_if #(.WIDTH(5)) sync_bus ();  // pin synchroniser link

  logic [5:1]   pin_sync;           // synchronised pin levels
  pbmux_state_t state;              // power-on sequencing state
  pbmux_state_t next_state;         // next sequencing state
  logic [2:0]   analog_en;          // analog channel enables
  logic [2:0]   next_analog_en;     // next analog enables
  logic [5:1]   next_pin;           // next pin drive level
  logic [5:1]   next_oe_n;          // next pin drive enable, low drives
  logic [5:1]   next_pullup;        // next pull-up enables
  logic [5:1]   next_dig_en;        // next digital input enables
  logic [5:1]   next_read;          // next port read value
  logic         next_ssp_clk;       // next serial clock input
  logic         next_i2c_sel;       // next clock buffer select
  logic         next_capture;       // next capture input
  logic         next_port_c;        // next channel 2 on port c
  logic         next_irq2;          // next external interrupt 2
  logic         next_change_irq_in_0;          // next change interrupt 0
  logic         next_change_irq_in_1;          // next change interrupt 1
  logic         next_lvp_entry;     // next programming entry
  logic [5:1]   analog_pin;         // analog function per pin
  logic [5:1]   pin_off;            // pins taken by programming
  logic         cc2_here;           // channel 2 routed to pin 3

  // synchroniser hookup
  // every pin level is asynchronous to the core clock, so nothing reads
  // it before two flops have settled it; the cost is two extra cycles of
  // latency on reads, captures and interrupt feeds
  // the synchronisers share the clock enable so a frozen core sees no
  // half-moved pin history when it resumes
  assign sync_bus.ce  = ce_in;
  assign sync_bus.raw = pin_level_in;
  assign pin_sync     = sync_bus.synced;

  pbmux_sync #(
    .WIDTH (5)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .sync_bus    (sync_bus)
  );

  // power-on analog default and software analog writes
  // the default is caught on the first enabled edge after reset, so a
  // software write in that same cycle is lost; firmware must wait one
  // enabled cycle after reset before it writes the analog enables
  always_comb
  begin
    next_state     = state;
    next_analog_en = analog_en;
    if (ce_in)
    begin
      unique case (state)
        PBMUX_ST_STRAP:
        begin
          // catch the default once, after reset release
          next_analog_en = {3{por_analog_default_in}};
          next_state     = PBMUX_ST_RUN;
        end
        PBMUX_ST_RUN:
        begin
          if (analog_write_in)
          begin
            next_analog_en = analog_enable_data_in;
          end
        end
      endcase
    end
  end

  // sequencing registers
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state     <= PBMUX_ST_STRAP;
      analog_en <= `PBMUX_RST_ANALOG;
    end
    else
    begin
      state     <= next_state;
      analog_en <= next_analog_en;
    end
  end

  // per-pin function selection
  // priority, highest first: programming or debug ownership, serial clock
  // on pin 1, usb data on pins 2 and 3, compare on pin 3, parallel port
  // select on pin 4, then the plain output latch
  // an analog pin loses its digital input and pull-up; its driven value is kept
  always_comb
  begin
    // analog channels 8, 9, 11 sit on pins 2, 3, 4 as inputs
    analog_pin = 5'h00;
    analog_pin[`PBMUX_PIN_2] = analog_en[`PBMUX_AN_CH8]
                               & pin_direction_bit_in[`PBMUX_PIN_2];
    analog_pin[`PBMUX_PIN_3] = analog_en[`PBMUX_AN_CH9]
                               & pin_direction_bit_in[`PBMUX_PIN_3];
    analog_pin[`PBMUX_PIN_4] = analog_en[`PBMUX_AN_CH11]
                               & pin_direction_bit_in[`PBMUX_PIN_4];
    // programming or debug access owns its pins
    pin_off = DEBUG_PIN_MASK
              & {5{in_circuit_programming_in | in_circuit_debug_in}};
    // low-voltage programming owns pin 5 regardless of direction
    pin_off[`PBMUX_PIN_5] = pin_off[`PBMUX_PIN_5]
                            | low_voltage_prog_enable_in;
    cc2_here = ~cc2_pin_select_in;

    for (int i = `PBMUX_PIN_LO; i <= `PBMUX_PIN_HI; i++)
    begin
      // digital input path off for analog or owned pins
      next_dig_en[i] = ~pin_off[i] & ~analog_pin[i];
      // pull-up only on digital inputs with control low
      next_pullup[i] = next_dig_en[i] & pin_direction_bit_in[i]
                       & ~pullup_disable_n_in;
      // output pins drive the latch, analog does not matter
      next_oe_n[i]   = pin_off[i] | pin_direction_bit_in[i];
      next_pin[i]    = port_b_output_latch_in[i] & ~pin_off[i];
      // input pins read the settled level
      next_read[i]   = pin_sync[i] & next_dig_en[i];
    end

    // serial clock output beats the latch on pin 1
    // the override ignores the direction bit: the serial port, not the
    // port logic, decides when the clock pin is an output
    if (ssp_clk_drive_in & ~pin_off[`PBMUX_PIN_SCLK])
    begin
      next_pin[`PBMUX_PIN_SCLK]  = ssp_clk_level_in;
      next_oe_n[`PBMUX_PIN_SCLK] = 1'b0;
    end

    // pin 2: usb minus data when output
    if (usb_xcvr_enable_in & ~pin_direction_bit_in[`PBMUX_PIN_2]
        & ~pin_off[`PBMUX_PIN_2])
    begin
      next_pin[`PBMUX_PIN_2] = usb_xcvr_minus_data_in;
    end

    // pin 3: usb plus data first, else compare output
    // usb wins so a transceiver link is never corrupted by a stray
    // compare match while both are switched on
    if (~pin_direction_bit_in[`PBMUX_PIN_3] & ~pin_off[`PBMUX_PIN_3])
    begin
      if (usb_xcvr_enable_in)
      begin
        next_pin[`PBMUX_PIN_3] = usb_xcvr_plus_data_in;
      end
      else if (cc2_here)
      begin
        next_pin[`PBMUX_PIN_3] = cc2_compare_in;
      end
    end

    // pin 4: parallel port select on larger packages
    // on smaller packages the parameter removes this path entirely
    if (HAS_PARALLEL_PORT & parallel_port_enable_in
        & ~pin_direction_bit_in[`PBMUX_PIN_4] & ~pin_off[`PBMUX_PIN_4])
    begin
      next_pin[`PBMUX_PIN_4] = parallel_port_select_in;
    end

    // serial clock input and its buffer choice
    next_ssp_clk = pin_sync[`PBMUX_PIN_SCLK]
                   & next_dig_en[`PBMUX_PIN_SCLK];
    next_i2c_sel = ssp_i2c_mode_in;

    // capture input only when routed here and pin is input
    next_capture = cc2_here & pin_direction_bit_in[`PBMUX_PIN_3]
                   & next_read[`PBMUX_PIN_3];
    next_port_c  = cc2_pin_select_in;

    // interrupt sources from settled digital inputs
    // these are levels; edge and change detection live downstream, which
    // sees a clean level because the synchroniser already filtered it
    next_irq2 = pin_direction_bit_in[`PBMUX_PIN_2]
                & next_read[`PBMUX_PIN_2];
    next_change_irq_in_0 = pin_direction_bit_in[`PBMUX_PIN_4]
                & next_read[`PBMUX_PIN_4];
    next_change_irq_in_1 = pin_direction_bit_in[`PBMUX_PIN_5]
                & next_read[`PBMUX_PIN_5];

    // programming entry level on pin 5
    next_lvp_entry = low_voltage_prog_enable_in
                     & pin_sync[`PBMUX_PIN_5];
  end

  // output registers, frozen while the clock enable is low
  // registering every output keeps the pad drivers glitch free when
  // several controls change together in one cycle
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_out                  <= `PBMUX_RST_PIN_OUT;
      pin_oe_n_out             <= `PBMUX_RST_OE_N;
      pullup_enable_out        <= `PBMUX_RST_ZERO5;
      digital_input_enable_out <= `PBMUX_RST_ZERO5;
      port_b_pin_read_out      <= `PBMUX_RST_ZERO5;
      analog_enable_out        <= `PBMUX_RST_ANALOG;
      ssp_clk_pin_out          <= 1'b0;
      i2c_buffer_select_out    <= 1'b0;
      cc2_capture_out          <= 1'b0;
      cc2_on_port_c_out        <= 1'b0;
      ext_irq_2_in_out         <= 1'b0;
      change_irq_in_0_out      <= 1'b0;
      change_irq_in_1_out      <= 1'b0;
      lv_program_entry_out     <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_out                  <= next_pin;
      pin_oe_n_out             <= next_oe_n;
      pullup_enable_out        <= next_pullup;
      digital_input_enable_out <= next_dig_en;
      port_b_pin_read_out      <= next_read;
      analog_enable_out        <= analog_en;
      ssp_clk_pin_out          <= next_ssp_clk;
      i2c_buffer_select_out    <= next_i2c_sel;
      cc2_capture_out          <= next_capture;
      cc2_on_port_c_out        <= next_port_c;
      ext_irq_2_in_out         <= next_irq2;
      change_irq_in_0_out      <= next_change_irq_in_0;
      change_irq_in_1_out      <= next_change_irq_in_1;
      lv_program_entry_out     <= next_lvp_entry;
    end
  end

endmodule
`default_nettype wire

// ### sim/pbmux_props.sv
// assertion checker for the port b pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pbmux_props
  import pbmux_pkg::*;
#(
  parameter bit         HAS_PARALLEL_PORT = 1'b1,
  parameter logic [5:1] DEBUG_PIN_MASK    = 5'h10
)(
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       ce_in,
  input wire logic [5:1] pin_level_in,
  input wire logic [5:1] port_b_output_latch_in,
  input wire logic [5:1] pin_direction_bit_in,
  input wire logic       por_analog_default_in,
  input wire logic       cc2_pin_select_in,
  input wire logic       low_voltage_prog_enable_in,
  input wire logic       in_circuit_programming_in,
  input wire logic       in_circuit_debug_in,
  input wire logic       ssp_clk_drive_in,
  input wire logic       ssp_clk_level_in,
  input wire logic       cc2_compare_in,
  input wire logic       usb_xcvr_enable_in,
  input wire logic       usb_xcvr_minus_data_in,
  input wire logic       usb_xcvr_plus_data_in,
  input wire logic [5:1] pin_out,
  input wire logic [5:1] pin_oe_n_out,
  input wire logic [5:1] pullup_enable_out,
  input wire logic [5:1] digital_input_enable_out,
  input wire logic [5:1] port_b_pin_read_out,
  input wire logic [2:0] analog_enable_out
);
  wire logic       dbg;   // programming or debug access active
  logic      [2:0] hist;  // enabled, out-of-reset history of three edges
  wire logic [5:1] dir;   // short alias of the direction bits

  assign dbg = in_circuit_programming_in | in_circuit_debug_in;
  assign dir = pin_direction_bit_in;

  // tracks three running edges so sync latency can be judged
  always_ff @(posedge core_clk_in)
  begin
    hist <= {hist[1:0], ce_in & ~reset_in};
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_pullup_needs_dig: assert property (
    (pullup_enable_out & ~digital_input_enable_out) == 5'h00)
    else $error("pull-up on a pin without digital input");
  a_read_gated_dig: assert property (
    (port_b_pin_read_out & ~digital_input_enable_out) == 5'h00)
    else $error("port read set where digital input off");
  a_latch_drives_pin: assert property (
    ce_in && !dir[2] && !usb_xcvr_enable_in && !dbg |=>
    !pin_oe_n_out[2] && pin_out[2] == $past(port_b_output_latch_in[2]))
    else $error("output pin 2 does not follow latch");
  a_sclk_override: assert property (
    ce_in && ssp_clk_drive_in && !dbg |=>
    !pin_oe_n_out[1] && pin_out[1] == $past(ssp_clk_level_in))
    else $error("serial clock does not override pin 1");
  a_compare_on_pin3: assert property (
    ce_in && !cc2_pin_select_in && !dir[3] && !usb_xcvr_enable_in
    && !dbg |=> pin_out[3] == $past(cc2_compare_in))
    else $error("compare output missing on pin 3");
  a_usb_data_out: assert property (
    ce_in && usb_xcvr_enable_in && dir[3:2] == 2'b00 && !dbg |=>
    pin_oe_n_out[3:2] == 2'b00 && pin_out[3:2] ==
    $past({usb_xcvr_plus_data_in, usb_xcvr_minus_data_in}))
    else $error("usb transceiver data not on pins 2 and 3");
  a_lvp_owns_pin5: assert property (
    ce_in && low_voltage_prog_enable_in |=> pin_oe_n_out[5]
    && !pin_out[5] && !digital_input_enable_out[5])
    else $error("pin 5 still active in low-voltage programming");
  a_debug_pins_off: assert property (
    ce_in && dbg |=> (pin_oe_n_out & DEBUG_PIN_MASK) == DEBUG_PIN_MASK
    && (digital_input_enable_out & DEBUG_PIN_MASK) == 5'h00)
    else $error("debug pins not released");
  a_sync_three_edges: assert property (
    &hist |-> (port_b_pin_read_out & digital_input_enable_out) ==
    ($past(pin_level_in, 3) & digital_input_enable_out))
    else $error("pin read not three edges behind pin");
  a_por_analog_load: assert property (
    ce_in && $fell(reset_in) ##1 ce_in |=>
    analog_enable_out == {3{$past(por_analog_default_in, 2)}})
    else $error("analog default not loaded after reset");
endmodule

bind pbmux_top pbmux_props #(
  .HAS_PARALLEL_PORT(HAS_PARALLEL_PORT),
  .DEBUG_PIN_MASK   (DEBUG_PIN_MASK)
) u_props (.*);
`default_nettype wire

// ### sim/pbmux_board.sv
// board model: resolves the port b pin levels seen by the block
`timescale 1ns/1ps
`default_nettype none
module pbmux_board (
  input  wire logic [5:1] pin_out_in,
  input  wire logic [5:1] pin_oe_n_in,
  input  wire logic [5:1] pullup_in,
  input  wire logic [5:1] ext_drive_in,
  input  wire logic [5:1] ext_level_in,
  output logic      [5:1] pin_level_out
);
  // block drive wins, then board driver, then weak pull-up, else pull-down
  always_comb
  begin
    for (int i = 1; i <= 5; i++)
      pin_level_out[i] = !pin_oe_n_in[i] ? pin_out_in[i]
        : ext_drive_in[i] ? ext_level_in[i] : pullup_in[i];
  end
endmodule
`default_nettype wire

// ### sim/test_pbmux_top.sv
// self-checking testbench for the port b pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_pbmux_top;
  logic core_clk_in, reset_in, ce_in, pullup_disable_n_in;
  logic por_analog_default_in, cc2_pin_select_in, analog_write_in;
  logic low_voltage_prog_enable_in, in_circuit_programming_in;
  logic in_circuit_debug_in, ssp_clk_drive_in, ssp_clk_level_in;
  logic ssp_i2c_mode_in, cc2_compare_in, usb_xcvr_enable_in;
  logic usb_xcvr_minus_data_in, usb_xcvr_plus_data_in;
  logic parallel_port_enable_in, parallel_port_select_in;
  logic [5:1] pin_level_in, port_b_output_latch_in, pin_direction_bit_in;
  logic [5:1] pin_out, pin_oe_n_out, pullup_enable_out, ext_drive;
  logic [5:1] digital_input_enable_out, port_b_pin_read_out, ext_level;
  logic [2:0] analog_enable_data_in, analog_enable_out;
  logic ssp_clk_pin_out, i2c_buffer_select_out, cc2_capture_out;
  logic cc2_on_port_c_out, ext_irq_2_in_out, change_irq_in_0_out;
  logic change_irq_in_1_out, lv_program_entry_out;
  int   err_count, comparisons;

  pbmux_top dut (.*);
  pbmux_board board (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n_out),
    .pullup_in(pullup_enable_out), .ext_drive_in(ext_drive),
    .ext_level_in(ext_level), .pin_level_out(pin_level_in));

  // 200 MHz clock
  always #2.5 core_clk_in = ~core_clk_in;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // let pin-derived outputs run through sync and output register
  task automatic settle();
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr_an(input logic [2:0] d);
    @(posedge core_clk_in);
    analog_write_in       <= 1'b1;
    analog_enable_data_in <= d;
    @(posedge core_clk_in);
    analog_write_in <= 1'b0;
    settle();
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // analog default at power-on, then one channel by software
  task automatic t_analog();
    settle();
    chk({analog_enable_out, pullup_enable_out, port_b_pin_read_out,
      ssp_clk_pin_out}, {3'h7, 5'h11, 5'h11, 1'b1});
    wr_an(3'h2);
    chk({analog_enable_out, pullup_enable_out, digital_input_enable_out},
      {3'h2, 5'h1B, 5'h1B});
  endtask

  // digital inputs, interrupt feeds and sync latency
  task automatic t_input();
    @(posedge core_clk_in);
    pullup_disable_n_in <= 1'b1;
    ext_drive           <= 5'h1F;
    ext_level           <= 5'h1C;
    wr_an(3'h0);
    chk({pullup_enable_out, port_b_pin_read_out, ext_irq_2_in_out,
      change_irq_in_0_out, change_irq_in_1_out}, 13'h00E3);
    @(posedge core_clk_in);
    ext_level <= 5'h02;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(port_b_pin_read_out, 5'h1C);
    @(posedge core_clk_in);
    #1;
    chk({port_b_pin_read_out, ext_irq_2_in_out}, 6'h05);
  endtask

  // latch drives outputs, analog inert, clock enable freezes
  task automatic t_latch();
    @(posedge core_clk_in);
    ext_drive              <= 5'h00;
    pin_direction_bit_in   <= 5'h00;
    port_b_output_latch_in <= 5'h15;
    wr_an(3'h7);
    chk({pin_out, pin_oe_n_out, port_b_pin_read_out}, 15'h5415);
    @(posedge core_clk_in);
    ce_in                  <= 1'b0;
    port_b_output_latch_in <= 5'h01;
    settle();
    chk(pin_out, 5'h15);
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    settle();
    chk(pin_out, 5'h01);
  endtask

  // peripherals borrowing pins
  task automatic t_periph();
    @(posedge core_clk_in);
    ssp_clk_drive_in        <= 1'b1;
    ssp_i2c_mode_in         <= 1'b1;
    cc2_pin_select_in       <= 1'b0;
    cc2_compare_in          <= 1'b1;
    parallel_port_enable_in <= 1'b1;
    parallel_port_select_in <= 1'b1;
    settle();
    chk({pin_out, i2c_buffer_select_out, cc2_on_port_c_out},
      7'h32);
    @(posedge core_clk_in);
    usb_xcvr_enable_in     <= 1'b1;
    usb_xcvr_minus_data_in <= 1'b1;
    settle();
    chk(pin_out, 5'h0A);
    @(posedge core_clk_in);
    usb_xcvr_enable_in   <= 1'b0;
    pin_direction_bit_in <= 5'h04;
    ext_drive            <= 5'h04;
    ext_level            <= 5'h04;
    // analog off on pin 3 so the capture sees the digital level
    wr_an(3'h0);
    chk({cc2_capture_out, pin_oe_n_out[3]}, 2'b11);
    @(posedge core_clk_in);
    cc2_pin_select_in <= 1'b1;
    settle();
    chk({cc2_capture_out, cc2_on_port_c_out}, 2'b01);
  endtask

  // programming entry and debug take pin 5
  task automatic t_prog();
    @(posedge core_clk_in);
    low_voltage_prog_enable_in <= 1'b1;
    pin_direction_bit_in       <= 5'h00;
    port_b_output_latch_in     <= 5'h10;
    ext_drive                  <= 5'h10;
    ext_level                  <= 5'h10;
    settle();
    chk({pin_oe_n_out[5], lv_program_entry_out, change_irq_in_1_out,
      port_b_pin_read_out[5]}, 4'hC);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge core_clk_in);
      low_voltage_prog_enable_in <= 1'b0;
      in_circuit_debug_in        <= (m == 0);
      in_circuit_programming_in  <= (m == 1);
      settle();
      chk({pin_oe_n_out[5], digital_input_enable_out[5],
        lv_program_entry_out}, 3'h4);
    end
  endtask

  initial
  begin
    {core_clk_in, ce_in, reset_in} = 3'h7;
    {pullup_disable_n_in, analog_write_in, analog_enable_data_in} = 5'h00;
    {low_voltage_prog_enable_in, in_circuit_programming_in} = 2'h0;
    {in_circuit_debug_in, ssp_clk_drive_in, ssp_clk_level_in} = 3'h0;
    {ssp_i2c_mode_in, cc2_compare_in, usb_xcvr_enable_in} = 3'h0;
    {usb_xcvr_minus_data_in, usb_xcvr_plus_data_in} = 2'h0;
    {parallel_port_enable_in, parallel_port_select_in} = 2'h0;
    {por_analog_default_in, cc2_pin_select_in} = 2'h3;
    {ext_drive, ext_level, port_b_output_latch_in} = 15'h0000;
    pin_direction_bit_in = 5'h1F;
    {err_count, comparisons} = 0;
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_analog();
    t_input();
    t_latch();
    t_periph();
    t_prog();
    summarize();
  end

  // cuts a hang short
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
